// ===== mode_regs_pkg.sv
// Package: register map, fields, reset values and timing for the mode bank
package mode_regs_pkg;

    localparam int unsigned PTR_W = 8;
    localparam int unsigned DATA_W = 8;

    // Register pointer values
    localparam logic [5:0] ADDR_MODE_ZERO = 6'h00;
    localparam logic [5:0] ADDR_MODE_ONE  = 6'h01;
    localparam logic [5:0] ADDR_MODE_TWO  = 6'h02;
    localparam logic [5:0] ADDR_LAST      = 6'h02;

    // Field positions
    localparam int unsigned STD_LSB    = 0;
    localparam int unsigned LUMA_LSB   = 2;
    localparam int unsigned CHROMA_LSB = 5;
    localparam int unsigned ILACE_BIT  = 0;
    localparam int unsigned CAP_LSB    = 1;
    localparam int unsigned DAC_A_BIT  = 3;
    localparam int unsigned RSV1_BIT   = 4;
    localparam int unsigned DAC_B_BIT  = 5;
    localparam int unsigned DAC_C_BIT  = 6;
    localparam int unsigned BARS_BIT   = 7;
    localparam int unsigned SQPIX_BIT  = 0;
    localparam int unsigned GLIN_BIT   = 1;
    localparam int unsigned GLKIND_BIT = 2;
    localparam int unsigned LINE_BIT   = 3;
    localparam int unsigned CHR_BIT    = 4;
    localparam int unsigned BURST_BIT  = 5;
    localparam int unsigned LOWP_BIT   = 6;
    localparam int unsigned RSV0_BIT   = 7;

    // Reset values: DACs A and C powered down, all else zero
    localparam logic [7:0] RST_MODE_ZERO = 8'h00;
    localparam logic [7:0] RST_MODE_ONE  = 8'h48;
    localparam logic [7:0] RST_MODE_TWO  = 8'h00;
    localparam logic [7:0] RST_POINTER   = 8'h00;
    localparam logic [1:0] PTR_TOP_ZERO  = 2'h0;
    localparam logic [7:0] READ_ZERO     = 8'h00;

    // Output standard codes
    typedef enum logic [1:0] {
        STD_NTSC   = 2'h0,
        STD_PAL_BG = 2'h1,
        STD_PAL_MN = 2'h2,
        STD_RSVD   = 2'h3
    } output_standard_mode_t;

    // Active line length in pixels
    localparam logic [9:0] LINE_LEN_FULL = 10'h2D0;
    localparam logic [9:0] LINE_LEN_NTSC = 10'h2C6;
    localparam logic [9:0] LINE_LEN_PAL  = 10'h2BE;

    // Host engine: pause between transfers
    localparam int unsigned CLK_HZ       = 10_000_000;
    localparam int unsigned GAP_NS       = 200;
    localparam int unsigned GAP_CYCLES   =
        (GAP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

endpackage

// ===== mode_link_if.sv
// Interface: byte-level two-wire transfer link between host and bank
`timescale 1ns/1ps
interface mode_link_if;
    logic       start;      // Transfer opens, pointer byte follows
    logic       wr_valid;   // Data byte strobe, write direction
    logic [7:0] wr_data;
    logic       rd_req;     // Read byte request
    logic       stop;       // Transfer closes
    logic       ack;        // Byte acknowledged by bank
    logic       nack;       // Byte refused by bank
    logic [7:0] rd_data;
    logic       rd_valid;

    modport device (
        input  start, wr_valid, wr_data, rd_req, stop,
        output ack, nack, rd_data, rd_valid
    );
    modport host (
        output start, wr_valid, wr_data, rd_req, stop,
        input  ack, nack, rd_data, rd_valid
    );
endinterface

// ===== mode_regs_bank.sv
// Device end: pointer and three mode registers with decoded controls
//
// What this block does
// - Write-only 8-bit pointer selects transfer target
// - Host writes zeros into pointer top bits
// - Pointer low six bits give start register
// - Pointer 0,1,2 decode mode registers 0,1,2
// - Mode zero low bits select TV standard
// - Luma filter field independent of standard
// - Chroma filter field in mode zero top
// - Mode one bit zero selects interlace
// - Two bits choose caption field(s)
// - Three bits power down individual DACs
// - Host writes one into reserved bit
// - Top bit enables internal colour bars
// - Colour bars force timing master
// - Square pixel only in slave timing
// - Genlock bit makes shared pin input
// - Rising pin edge resets subcarrier sequence
// - Otherwise pin carries real-time lock data
// - Line length 720, or 710/702 pixels
// - Separate chroma and burst enables
// - Low-power mode cuts DAC current
// - Host writes zero into reserved top
// - DACs A and C powered down at reset
// - Pointer advances after each accepted write and each read below register 2
`timescale 1ns/1ps
module mode_regs_bank
    import mode_regs_pkg::*;
(
    // Clock and reset
    input  wire logic                          mclk,
    input  wire logic                          rst_n,
    // Byte link from host
    mode_link_if.device                        link,
    // Genlock pin and timing request
    input  wire logic                          subcarrier_lock_pin,
    input  wire logic                          slave_timing_req,
    // Decoded controls
    output mode_regs_pkg::output_standard_mode_t output_standard_mode,
    output logic [2:0]                         luma_filter_select,
    output logic [2:0]                         chroma_filter_select,
    output logic                               interlace_select,
    output logic [1:0]                         caption_field_select,
    output logic                               dac_a_powerdown,
    output logic [1:0]                         dac_bc_powerdown,
    output logic                               color_bar_enable,
    output logic                               timing_master,
    output logic                               square_pixel_active,
    output logic                               subcarrier_lock_oe_n,
    output logic                               subcarrier_reset,
    output logic                               rtc_lock_valid,
    output logic                               rtc_lock_data,
    output logic [9:0]                         active_line_length,
    output logic                               chroma_output_enable,
    output logic                               burst_output_enable,
    output logic                               low_power_enable
);
    import mode_regs_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_POINTER,
        ST_DATA
    } phase_t;

    typedef struct packed {
        phase_t     phase;
        logic [7:0] pointer;
        logic [7:0] mode_zero;
        logic [7:0] mode_one;
        logic [7:0] mode_two;
        logic       ack;
        logic       nack;
        logic [7:0] rd_data;
        logic       rd_valid;
        logic       pin_prev;
        logic       sc_reset;
        logic       rtc_valid;
        logic       rtc_data;
    } bank_state_t;

    bank_state_t s_q;
    bank_state_t s_d;
    logic [5:0]  sel;
    logic [7:0]  rd_word;

    assign sel = s_q.pointer[5:0];

    always_comb begin
        unique case (sel)
            ADDR_MODE_ZERO: rd_word = s_q.mode_zero;
            ADDR_MODE_ONE:  rd_word = s_q.mode_one;
            ADDR_MODE_TWO:  rd_word = s_q.mode_two;
            default:        rd_word = READ_ZERO;
        endcase
    end

    always_comb begin
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.nack = 1'b0;
        s_d.rd_valid = 1'b0;
        s_d.sc_reset = 1'b0;
        s_d.rtc_valid = 1'b0;
        s_d.pin_prev = subcarrier_lock_pin;
        if (link.start) begin
            s_d.phase = ST_POINTER;
        end else if (link.stop) begin
            s_d.phase = ST_IDLE;
        end else begin
            unique case (s_q.phase)
                ST_IDLE: begin
                end
                ST_POINTER: begin
                    if (link.wr_valid) begin
                        // Pointer is never readable back
                        s_d.pointer = link.wr_data;
                        if (link.wr_data[5:0] > ADDR_LAST) begin
                            s_d.nack = 1'b1;
                            s_d.phase = ST_IDLE;
                        end else begin
                            s_d.ack = 1'b1;
                            s_d.phase = ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    if (link.wr_valid) begin
                        if (sel > ADDR_LAST) begin
                            s_d.nack = 1'b1;
                            s_d.phase = ST_IDLE;
                        end else begin
                            // Whole byte lands at once
                            unique case (sel)
                                ADDR_MODE_ZERO: s_d.mode_zero = link.wr_data;
                                ADDR_MODE_ONE:  s_d.mode_one = link.wr_data;
                                default:        s_d.mode_two = link.wr_data;
                            endcase
                            s_d.ack = 1'b1;
                            s_d.pointer = s_q.pointer + 8'h01;
                        end
                    end else if (link.rd_req) begin
                        s_d.rd_data = rd_word;
                        s_d.rd_valid = 1'b1;
                        // At the last register the pointer holds, so it repeats
                        if (sel < ADDR_LAST) begin
                            s_d.pointer = s_q.pointer + 8'h01;
                        end
                    end
                end
                default: s_d.phase = ST_IDLE;
            endcase
        end
        // Shared pin as input only when enabled
        if (s_q.mode_two[GLIN_BIT]) begin
            if (!s_q.mode_two[GLKIND_BIT]) begin
                s_d.sc_reset = subcarrier_lock_pin
                               && !s_q.pin_prev;
            end else begin
                s_d.rtc_valid = 1'b1;
                s_d.rtc_data = subcarrier_lock_pin;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{phase: ST_IDLE, pointer: RST_POINTER,
                     mode_zero: RST_MODE_ZERO,
                     mode_one: RST_MODE_ONE,
                     mode_two: RST_MODE_TWO, ack: 1'b0, nack: 1'b0,
                     rd_data: READ_ZERO, rd_valid: 1'b0,
                     pin_prev: 1'b0, sc_reset: 1'b0,
                     rtc_valid: 1'b0, rtc_data: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign link.ack = s_q.ack;
    assign link.nack = s_q.nack;
    assign link.rd_data = s_q.rd_data;
    assign link.rd_valid = s_q.rd_valid;

    // Mode zero fields
    assign output_standard_mode =
        output_standard_mode_t'(s_q.mode_zero[STD_LSB +: 2]);
    assign luma_filter_select = s_q.mode_zero[LUMA_LSB +: 3];
    assign chroma_filter_select = s_q.mode_zero[CHROMA_LSB +: 3];
    // Mode one fields
    assign interlace_select = s_q.mode_one[ILACE_BIT];
    assign caption_field_select = s_q.mode_one[CAP_LSB +: 2];
    assign dac_a_powerdown = s_q.mode_one[DAC_A_BIT];
    assign dac_bc_powerdown = {s_q.mode_one[DAC_C_BIT],
                               s_q.mode_one[DAC_B_BIT]};
    assign color_bar_enable = s_q.mode_one[BARS_BIT];
    // Bars override any slave timing request
    assign timing_master = s_q.mode_one[BARS_BIT] || !slave_timing_req;
    // Square pixel honoured only when slaved
    assign square_pixel_active = s_q.mode_two[SQPIX_BIT] && !timing_master;
    assign subcarrier_lock_oe_n = s_q.mode_two[GLIN_BIT];
    assign subcarrier_reset = s_q.sc_reset;
    assign rtc_lock_valid = s_q.rtc_valid;
    assign rtc_lock_data = s_q.rtc_data;
    // Line length by standard
    assign active_line_length = !s_q.mode_two[LINE_BIT] ? LINE_LEN_FULL :
        (output_standard_mode == STD_NTSC) ? LINE_LEN_NTSC : LINE_LEN_PAL;
    assign chroma_output_enable = s_q.mode_two[CHR_BIT];
    assign burst_output_enable = s_q.mode_two[BURST_BIT];
    assign low_power_enable = s_q.mode_two[LOWP_BIT];
endmodule

// ===== mode_regs_host.sv
// Host end: issues pointer-then-data transfers to the mode bank
`timescale 1ns/1ps
module mode_regs_host
    import mode_regs_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // User command
    input  wire logic       cmd_valid,
    input  wire logic       cmd_write,
    input  wire logic [5:0] cmd_addr,
    input  wire logic [7:0] cmd_wdata,
    output logic            cmd_ready,
    output logic            cmd_done,
    output logic            cmd_error,
    output logic [7:0]      cmd_rdata,
    // Byte link to bank
    mode_link_if.host       link
);
    import mode_regs_pkg::*;

    typedef enum logic [2:0] {
        H_IDLE,
        H_START,
        H_POINTER,
        H_DATA,
        H_WAIT,
        H_STOP,
        H_GAP
    } hphase_t;

    typedef struct packed {
        hphase_t    phase;
        logic       write;
        logic [5:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic       done;
        logic       error;
        logic [3:0] gap;
    } host_state_t;

    host_state_t h_q;
    host_state_t h_d;

    // Legal bits forced on whatever the user supplies
    function automatic logic [7:0] legalize(input logic [5:0] a,
                                            input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == ADDR_MODE_ONE) begin
            v[RSV1_BIT] = 1'b1;
        end
        if (a == ADDR_MODE_TWO) begin
            v[RSV0_BIT] = 1'b0;
        end
        return v;
    endfunction

    always_comb begin
        h_d = h_q;
        h_d.done = 1'b0;
        unique case (h_q.phase)
            H_IDLE: begin
                if (cmd_valid) begin
                    h_d.write = cmd_write;
                    h_d.addr = cmd_addr;
                    h_d.wdata = legalize(cmd_addr, cmd_wdata);
                    h_d.phase = H_START;
                end
            end
            H_START: h_d.phase = H_POINTER;
            H_POINTER: begin
                if (link.ack) begin
                    h_d.phase = H_DATA;
                end else if (link.nack) begin
                    h_d.error = 1'b1;
                    h_d.phase = H_STOP;
                end
            end
            H_DATA: h_d.phase = H_WAIT;
            H_WAIT: begin
                if (link.rd_valid) begin
                    h_d.rdata = link.rd_data;
                    h_d.error = 1'b0;
                    h_d.phase = H_STOP;
                end else if (link.ack || link.nack) begin
                    h_d.error = link.nack;
                    h_d.phase = H_STOP;
                end
            end
            H_STOP: begin
                h_d.done = 1'b1;
                h_d.gap = 4'(GAP_CYCLES);
                h_d.phase = H_GAP;
            end
            H_GAP: begin
                if (h_q.gap <= 4'h1) begin
                    // Clear so the next pointer byte is not held back
                    h_d.gap = 4'h0;
                    h_d.phase = H_IDLE;
                end else begin
                    h_d.gap = h_q.gap - 4'h1;
                end
            end
            default: h_d.phase = H_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            h_q <= '{phase: H_IDLE, write: 1'b0, addr: 6'h00,
                     wdata: 8'h00, rdata: 8'h00, done: 1'b0,
                     error: 1'b0, gap: 4'h0};
        end else begin
            h_q <= h_d;
        end
    end

    assign cmd_ready = (h_q.phase == H_IDLE);
    assign cmd_done = h_q.done;
    assign cmd_error = h_q.error;
    assign cmd_rdata = h_q.rdata;

    assign link.start = (h_q.phase == H_START);
    // Top pointer bits always zero
    assign link.wr_valid = (h_q.phase == H_POINTER && !link.ack
                            && !link.nack && h_q.gap == 4'h0)
                           || (h_q.phase == H_DATA && h_q.write);
    assign link.wr_data = (h_q.phase == H_DATA) ? h_q.wdata
                          : {PTR_TOP_ZERO, h_q.addr};
    assign link.rd_req = (h_q.phase == H_DATA) && !h_q.write;
    assign link.stop = (h_q.phase == H_STOP);
endmodule

// ===== mode_regs_assertions.sv
// Checker: link answers and register contents seen on the byte link
`timescale 1ns/1ps
module mode_regs_assertions
    import mode_regs_pkg::*;
(
    // Clock and reset
    input wire logic       mclk,
    input wire logic       rst_n,
    // Link signals
    input wire logic       start,
    input wire logic       wr_valid,
    input wire logic [7:0] wr_data,
    input wire logic       rd_req,
    input wire logic       stop,
    input wire logic       ack,
    input wire logic       nack,
    input wire logic [7:0] rd_data,
    input wire logic       rd_valid
);
    logic [1:0] phase_q;
    logic [5:0] ptr_q;
    logic [7:0] shadow_q [3];
    logic       ptr_byte;
    logic       data_wr;
    logic       data_rd;
    logic [7:0] rd_exp;

    assign ptr_byte = wr_valid && phase_q == 2'h1;
    assign data_wr  = wr_valid && phase_q == 2'h2;
    assign data_rd  = rd_req && phase_q == 2'h2;
    // Reads past the last register keep returning it
    assign rd_exp   = shadow_q[(ptr_q > ADDR_LAST) ? 2'h2 : ptr_q[1:0]];

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q     <= 2'h0;
            ptr_q       <= 6'h00;
            shadow_q[0] <= RST_MODE_ZERO;
            shadow_q[1] <= RST_MODE_ONE;
            shadow_q[2] <= RST_MODE_TWO;
        end else if (start || stop) begin
            phase_q <= start ? 2'h1 : 2'h0;
        end else if (ptr_byte) begin
            phase_q <= (wr_data[5:0] <= ADDR_LAST) ? 2'h2 : 2'h0;
            ptr_q   <= wr_data[5:0];
        end else if (data_wr || data_rd) begin
            if (data_wr && ptr_q <= ADDR_LAST) begin
                shadow_q[ptr_q[1:0]] <= wr_data;
            end
            if (data_wr && ptr_q > ADDR_LAST) begin
                phase_q <= 2'h0;
            end
            if (ptr_q != 6'h3F) begin
                ptr_q <= ptr_q + 6'h01;
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_ptr_accept: assert property (
        ptr_byte && wr_data[5:0] <= ADDR_LAST |=> ack && !nack)
        else $error("mapped pointer byte not acknowledged");
    chk_ptr_refuse: assert property (
        ptr_byte && wr_data[5:0] > ADDR_LAST |=> nack && !ack)
        else $error("unmapped pointer byte not refused");
    chk_ptr_top_zero: assert property (
        ptr_byte |-> wr_data[7:6] == PTR_TOP_ZERO)
        else $error("pointer byte top bits not zero");
    chk_rsv_one_bit: assert property (
        data_wr && ptr_q == ADDR_MODE_ONE |-> wr_data[RSV1_BIT])
        else $error("reserved bit of mode one written as zero");
    chk_write_ack: assert property (
        data_wr && ptr_q <= ADDR_LAST |=> ack && !nack)
        else $error("data byte to mapped register not acknowledged");
    chk_read_data: assert property (
        data_rd |=> rd_valid && rd_data == $past(rd_exp))
        else $error("read data does not match register contents");
    chk_ack_cause: assert property (
        ack |-> $past(wr_valid))
        else $error("acknowledge without a byte");
    chk_nack_cause: assert property (
        nack |-> $past(wr_valid))
        else $error("refusal without a byte");
    chk_answer_excl: assert property (
        !(ack && nack) && !(rd_valid && (ack || nack)))
        else $error("conflicting answers on the link");
    chk_rd_cause: assert property (
        rd_valid |-> $past(data_rd))
        else $error("read data without a read request");
endmodule

// ===== video_encoder_mode_registers_test.sv
// Testbench: host and bank joined over the link, driven by host commands
`timescale 1ns/1ps
module video_encoder_mode_registers_test;
    import mode_regs_pkg::*;

    logic                  mclk;
    logic                  rst_n;
    logic                  cmd_valid;
    logic                  cmd_write;
    logic [5:0]            cmd_addr;
    logic [7:0]            cmd_wdata;
    logic                  cmd_ready;
    logic                  cmd_done;
    logic                  cmd_error;
    logic [7:0]            cmd_rdata;
    logic                  lock_pin;
    logic                  slave_req;
    output_standard_mode_t std_mode;
    logic [2:0]            luma;
    logic [2:0]            chroma;
    logic [1:0]            cap;
    logic [1:0]            dac_bc;
    logic [9:0]            line_len;
    logic                  ilace, dac_a, bars, tmaster, sqpix, oe_n;
    logic                  sc_reset, chr_en, burst_en, lowp;
    logic                  rtc_v, rtc_d;
    logic [7:0]            v;
    int                    fails;
    int                    total_checks;
    int                    pulses;

    mode_link_if link ();

    mode_regs_host mode_regs_host_i (
        .mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_ready(cmd_ready), .cmd_done(cmd_done), .cmd_error(cmd_error),
        .cmd_rdata(cmd_rdata), .link(link)
    );

    mode_regs_bank mode_regs_bank_i (
        .mclk(mclk), .rst_n(rst_n), .link(link),
        .subcarrier_lock_pin(lock_pin), .slave_timing_req(slave_req),
        .output_standard_mode(std_mode), .luma_filter_select(luma),
        .chroma_filter_select(chroma), .interlace_select(ilace),
        .caption_field_select(cap), .dac_a_powerdown(dac_a),
        .dac_bc_powerdown(dac_bc), .color_bar_enable(bars),
        .timing_master(tmaster), .square_pixel_active(sqpix),
        .subcarrier_lock_oe_n(oe_n), .subcarrier_reset(sc_reset),
        .rtc_lock_valid(rtc_v), .rtc_lock_data(rtc_d),
        .active_line_length(line_len), .chroma_output_enable(chr_en),
        .burst_output_enable(burst_en), .low_power_enable(lowp)
    );

    mode_regs_assertions mode_regs_assertions_i (
        .mclk(mclk), .rst_n(rst_n), .start(link.start),
        .wr_valid(link.wr_valid), .wr_data(link.wr_data),
        .rd_req(link.rd_req), .stop(link.stop), .ack(link.ack),
        .nack(link.nack), .rd_data(link.rd_data), .rd_valid(link.rd_valid)
    );

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [9:0] got, input logic [9:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // One host command, bounded waits on ready and done
    task automatic access(input logic wr, input logic [5:0] addr,
                          input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_addr  <= addr;
        cmd_wdata <= wd;
        @(negedge mclk);
        while (cmd_ready !== 1'b1 && n < 50) begin
            @(negedge mclk);
            n++;
        end
        @(posedge mclk);
        cmd_valid <= 1'b0;
        do begin
            @(negedge mclk);
            n++;
        end while (cmd_done !== 1'b1 && n < 100);
        if (n >= 100) begin
            fails++;
            $display("Error at %0t: got %0h expected %0h",
                     $time, cmd_done, 1'b1);
        end
    endtask

    task automatic wr(input logic [5:0] addr, input logic [7:0] wd);
        access(1'b1, addr, wd);
        check(cmd_error, 1'b0);
    endtask

    task automatic rd(input logic [5:0] addr, input logic [7:0] exp);
        access(1'b0, addr, 8'h00);
        check(cmd_error, 1'b0);
        check(cmd_rdata, exp);
    endtask

    // Rising pin edge, then count reset pulses
    task automatic pin_edge;
        @(posedge mclk);
        lock_pin <= 1'b0;
        repeat (3) @(posedge mclk);
        lock_pin <= 1'b1;
        pulses = 0;
        repeat (6) begin
            @(negedge mclk);
            if (sc_reset === 1'b1) begin
                pulses++;
            end
        end
    endtask

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    initial begin
        repeat (3000) @(posedge mclk);
        fails++;
        print_verdict();
    end

    initial begin
        rst_n = 1'b0;
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_addr = 6'h00;
        cmd_wdata = 8'h00;
        lock_pin = 1'b0;
        slave_req = 1'b1;
        fails = 0;
        total_checks = 0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        rd(ADDR_MODE_ZERO, RST_MODE_ZERO);
        rd(ADDR_MODE_ONE, RST_MODE_ONE);
        rd(ADDR_MODE_TWO, RST_MODE_TWO);
        check(dac_a, 1'b1);
        check(dac_bc, 2'h2);
        $display("test reset_values done");
        for (int i = 0; i < 3; i++) begin
            v = {i[2:0] + 3'h4, i[2:0] + 3'h1, i[1:0]};
            wr(ADDR_MODE_ZERO, v);
            check(std_mode, i[1:0]);
            check(luma, v[4:2]);
            check(chroma, v[7:5]);
            rd(ADDR_MODE_ZERO, v);
        end
        $display("test mode_zero done");
        wr(ADDR_MODE_ONE, 8'hA5);
        check(ilace, 1'b1);
        check(cap, 2'h2);
        check({dac_bc, dac_a}, 3'h2);
        check(bars, 1'b1);
        check(tmaster, 1'b1);
        rd(ADDR_MODE_ONE, 8'hB5);
        wr(ADDR_MODE_ONE, 8'h4A);
        check({ilace, cap}, 3'h1);
        check({dac_bc, dac_a}, 3'h5);
        check(tmaster, 1'b0);
        rd(ADDR_MODE_ONE, 8'h5A);
        $display("test mode_one done");
        wr(ADDR_MODE_ZERO, {6'h00, STD_NTSC});
        wr(ADDR_MODE_TWO, 8'hFF);
        rd(ADDR_MODE_TWO, 8'h7F);
        check(sqpix, 1'b1);
        check(oe_n, 1'b1);
        check(line_len, LINE_LEN_NTSC);
        check({chr_en, burst_en, lowp}, 3'h7);
        @(posedge mclk);
        slave_req <= 1'b0;
        @(negedge mclk);
        check(sqpix, 1'b0);
        wr(ADDR_MODE_ZERO, {6'h00, STD_PAL_BG});
        check(line_len, LINE_LEN_PAL);
        wr(ADDR_MODE_TWO, 8'h00);
        check(line_len, LINE_LEN_FULL);
        check({oe_n, chr_en, burst_en, lowp}, 4'h0);
        $display("test mode_two done");
        wr(ADDR_MODE_TWO, 8'h02);
        pin_edge();
        check(pulses, 1);
        check(rtc_v, 1'b0);
        wr(ADDR_MODE_TWO, 8'h06);
        pin_edge();
        check(pulses, 0);
        check({rtc_v, rtc_d}, 2'h3);
        $display("test genlock done");
        access(1'b0, 6'h03, 8'h00);
        check(cmd_error, 1'b1);
        access(1'b1, 6'h3F, 8'h55);
        check(cmd_error, 1'b1);
        rd(ADDR_MODE_TWO, 8'h06);
        $display("test unmapped done");
        print_verdict();
    end
endmodule
